// ==== gpa_defines.svh ====
// register map, reset values and field constants of the port block
`ifndef GPA_DEFINES_SVH
`define GPA_DEFINES_SVH

`define GPA_AW               9
`define GPA_DW               8
`define GPA_NPIN             6
`define GPA_NFN              5

`define GPA_OFS_PIN_LEVELS   9'h005
`define GPA_OFS_CHANGE_FLAGS 9'h008
`define GPA_OFS_OUT_LATCH    9'h105
`define GPA_OFS_FALL_ENABLE  9'h108
`define GPA_OFS_PULL_UP      9'h10c
`define GPA_OFS_DIRECTION    9'h085
`define GPA_OFS_ANALOG_SEL   9'h18e

`define GPA_RST_LATCH        6'h00
`define GPA_RST_FLAGS        6'h00
`define GPA_RST_FALL_EN      6'h00
`define GPA_RST_PULL_UP      6'h3f
`define GPA_RST_DIRECTION    6'h3f
`define GPA_RST_ANALOG_SEL   6'h37

`define GPA_PIN_FIRST        0
`define GPA_PIN_THIRD        2
`define GPA_PIN_IN_ONLY      3
`define GPA_MASK_IN_ONLY     6'h08
`define GPA_MASK_LATCH       6'h37
`define GPA_MASK_ANALOG      6'h37
`define GPA_CMP_SEL_FIRST    2'h0

`endif

// ==== gpa_pin_model.sv ====
// board side of the six port pads: external drivers, pull-ups, floating lines
`timescale 1ns/100ps
module gpa_pin_model (
  // clock
  input  wire logic       clk,
  // pad signals from the port
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oen,
  input  wire logic [5:0] pullup_en,
  // board drivers
  input  wire logic [5:0] ext_en,
  input  wire logic [5:0] ext_val,
  // resolved pad levels
  output logic      [5:0] pin_lvl
);
  logic [5:0] float_ff = 6'h15;

  // a floating line wanders each cycle so no test leans on a stale level
  always @(posedge clk) begin
    float_ff <= ~float_ff;
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pin_oen[i]) begin
        pin_lvl[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] = ext_val[i];
      end else if (pullup_en[i]) begin
        pin_lvl[i] = 1'b1;
      end else begin
        pin_lvl[i] = float_ff[i];
      end
    end
  end
endmodule

// ==== gpa_pin_mux.sv ====
// fixed priority selector of the functions sharing one pin
`timescale 1ns/100ps
module gpa_pin_mux #(
  parameter int NFN = 5
) (
  // functions, entry 0 highest, last entry is the port itself
  input  gpa_pkg::gpa_fn_type fns [NFN],
  // winning function
  output gpa_pkg::gpa_fn_type sel
);

  gpa_pkg::gpa_fn_type chain [NFN];

  // the port entry closes the chain so some owner always exists
  assign chain[NFN-1] = fns[NFN-1];

  genvar i;
  generate
    for (i = 0; i < NFN - 1; i++) begin : g_prio
      assign chain[i] = fns[i].en ? fns[i] : chain[i+1]; // [R11] [R20]
    end
  endgenerate

  assign sel = chain[0];

endmodule

// ==== gpa_pkg.sv ====
// shared types of the port block
package gpa_pkg;

  // one function that may own a pin: enabled, output driver on, driven level
  typedef struct packed {
    logic en;
    logic drive;
    logic dat;
  } gpa_fn_type;

  // owner of a pin after arbitration, highest priority first
  typedef enum logic [2:0] {
    GPA_OWN_F0   = 3'h0,
    GPA_OWN_F1   = 3'h1,
    GPA_OWN_F2   = 3'h2,
    GPA_OWN_F3   = 3'h3,
    GPA_OWN_PORT = 3'h4
  } gpa_owner_type;

endpackage

// ==== gpa_port.sv ====
// six-pin general purpose port with shared-function priority and register access
//
// How it works
// (R1) six pins: five bidirectional, one input only.
// (R2) direction bit one makes the pin an input, driver off.
// (R3) direction bit zero enables the driver and drives the output latch.
// (R4) input-only pin never drives; its direction bit always reads one.
// (R5) port read returns pin levels; port write updates the output latch.
// (R6) every port write loads only the written bits into the output latch; no pin level is sampled.
// (R7) with master clear enabled, the input-only pin reads zero.
// (R8) direction bits still steer drivers on analog pins; software keeps them set.
// (R9) an analog pin always reads zero in the port data register.
// (R10) an analog pin cannot raise any change interrupt.
// (R11) with several output functions enabled, the highest priority one owns the pin.
// (R12) analog inputs connect only when peripheral enabled and selector points at pin.
// (R13) analog mode disables the pin's digital input buffer.
// (R14) digital outputs may still drive an analog-mode pin, same priority order.
// (R15) first pin: programming data, reference out, converter out, comparator in, port.
// (R16) third pin: fault in, timer clock in, comparator one out, ext interrupt, port.
// (R17) the six pull-up enables reset to all ones on every reset.
// (R18) analog select bits reset to analog; software clears them for digital use.
// (R19) a pin's pull-up switches off whenever the pin is driven.
// (R20) per-pin output choice is a fixed combinational priority mux every cycle.
`timescale 1ns/100ps
`include "gpa_defines.svh"
module gpa_port (
  // clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RSTN,
  // register port
  input  wire logic [`GPA_AW-1:0]         ADDR,
  input  wire logic [`GPA_DW-1:0]         WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output logic      [`GPA_DW-1:0]         RDATA,
  // pins
  input  wire logic [`GPA_NPIN-1:0]       PIN_IN,
  output logic      [`GPA_NPIN-1:0]       PIN_OUT,
  output logic      [`GPA_NPIN-1:0]       PIN_OEN,
  output logic      [`GPA_NPIN-1:0]       PULLUP_EN,
  // digital pin levels to peripherals and change event
  output logic      [`GPA_NPIN-1:0]       PIN_DIN,
  output logic                            CHANGE_INT,
  // device configuration
  input  wire logic                       MASTER_CLEAR_ENABLE,
  // first pin functions
  input  wire gpa_pkg::gpa_fn_type        SERIAL_PROG_DATA,
  input  wire logic                       VREF_OUT_EN,
  input  wire logic                       CONVERTER_OUT_EN,
  input  wire logic                       CMP_ONE_EN,
  input  wire logic [1:0]                 CMP_POS_SEL,
  // third pin functions
  input  wire logic                       DRIVE_FAULT_EN,
  input  wire logic                       TIMER_CLOCK_EN,
  input  wire gpa_pkg::gpa_fn_type        CMP_ONE_OUTPUT,
  input  wire logic                       EXT_INT_EN,
  // analog connection of the first pin to the comparator input
  output logic                            CMP_POS_CONNECT
);

  localparam int NP = `GPA_NPIN;
  localparam int NF = `GPA_NFN;

  // registers
  logic [NP-1:0] latch_ff;
  logic [NP-1:0] dir_ff;
  logic [NP-1:0] ansel_ff;
  logic [NP-1:0] wpu_ff;
  logic [NP-1:0] fall_en_ff;
  logic [NP-1:0] flags_ff;
  logic [NP-1:0] din_prev_ff;
  logic [NP-1:0] pin_out_ff;
  logic [NP-1:0] pin_oen_ff;
  logic [NP-1:0] pullup_ff;
  logic [NP-1:0] din_ff;
  logic [`GPA_DW-1:0] rdata_ff;
  logic          int_ff;
  logic          cmp_conn_ff;

  logic [NP-1:0] nxt_latch;
  logic [NP-1:0] nxt_dir;
  logic [NP-1:0] nxt_ansel;
  logic [NP-1:0] nxt_wpu;
  logic [NP-1:0] nxt_fall_en;
  logic [NP-1:0] nxt_flags;
  logic [`GPA_DW-1:0] nxt_rdata;

  // address decode
  wire hit_levels = (ADDR == `GPA_OFS_PIN_LEVELS);
  wire hit_flags  = (ADDR == `GPA_OFS_CHANGE_FLAGS);
  wire hit_latch  = (ADDR == `GPA_OFS_OUT_LATCH);
  wire hit_fall   = (ADDR == `GPA_OFS_FALL_ENABLE);
  wire hit_wpu    = (ADDR == `GPA_OFS_PULL_UP);
  wire hit_dir    = (ADDR == `GPA_OFS_DIRECTION);
  wire hit_ansel  = (ADDR == `GPA_OFS_ANALOG_SEL);

  wire wr_levels  = WR && hit_levels;
  wire wr_latch   = WR && hit_latch;
  wire wr_port    = wr_levels || wr_latch;
  wire wr_flags   = WR && hit_flags;
  wire wr_fall    = WR && hit_fall;
  wire wr_wpu     = WR && hit_wpu;
  wire wr_dir     = WR && hit_dir;
  wire wr_ansel   = WR && hit_ansel;

  // digital input buffer, off for analog pins so a mid-level input draws no current
  wire [NP-1:0] din = PIN_IN & ~ansel_ff; // [R13] [R9]

  // port read view: pin levels, input-only pin hidden under master clear
  wire [NP-1:0] in_only_mask = MASTER_CLEAR_ENABLE ? `GPA_MASK_IN_ONLY : 6'h00;
  wire [NP-1:0] port_view    = din & ~in_only_mask; // [R5] [R7]

  // read-modify-write: the sampled-pin term masks to zero, so the latch takes only
  // the written bits and the input-only pin's latch bit always loads zero
  wire [NP-1:0] wr_bits   = WDATA[NP-1:0] & `GPA_MASK_LATCH;
  wire [NP-1:0] rmw_value = wr_bits | (port_view & ~`GPA_MASK_LATCH & `GPA_MASK_LATCH); // [R6]

  assign nxt_latch   = wr_port  ? rmw_value : latch_ff; // [R5] [R6]
  assign nxt_dir     = wr_dir   ? (WDATA[NP-1:0] | `GPA_MASK_IN_ONLY) : dir_ff; // [R4]
  assign nxt_ansel   = wr_ansel ? (WDATA[NP-1:0] & `GPA_MASK_ANALOG) : ansel_ff;
  assign nxt_wpu     = wr_wpu   ? WDATA[NP-1:0] : wpu_ff;
  assign nxt_fall_en = wr_fall  ? WDATA[NP-1:0] : fall_en_ff;

  // falling edge on a digital pin; analog pins read zero and are gated off too
  wire [NP-1:0] fall_evt  = din_prev_ff & ~din & fall_en_ff & ~ansel_ff; // [R10]
  wire [NP-1:0] flag_keep = wr_flags ? (flags_ff & WDATA[NP-1:0]) : flags_ff;
  // a new edge wins over a clear in the same cycle
  assign nxt_flags = flag_keep | fall_evt;

  // read mux, unmapped addresses read zero and bits above the port read zero
  wire [NP-1:0] rd_sel =
    hit_levels ? port_view  :
    hit_flags  ? flags_ff   :
    hit_latch  ? latch_ff   :
    hit_fall   ? fall_en_ff :
    hit_wpu    ? wpu_ff     :
    hit_dir    ? dir_ff     :
    hit_ansel  ? ansel_ff   : 6'h00;
  assign nxt_rdata = RD ? {2'h0, rd_sel} : 8'h00;

  // per-pin function lists and arbitration
  gpa_pkg::gpa_fn_type fn_tab [NP][NF];
  gpa_pkg::gpa_fn_type owner  [NP];
  gpa_pkg::gpa_fn_type off_fn;
  assign off_fn = '{en: 1'b0, drive: 1'b0, dat: 1'b0};

  // comparator input joins the first pin only when enabled and selected there
  wire cmp_pos_on = CMP_ONE_EN && (CMP_POS_SEL == `GPA_CMP_SEL_FIRST); // [R12]

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_pin
      // port function: driver follows the direction bit even in analog mode
      gpa_pkg::gpa_fn_type port_fn;
      if (p == `GPA_PIN_IN_ONLY) begin : g_in_only
        assign port_fn = '{en: 1'b1, drive: 1'b0, dat: 1'b0}; // [R4] [R1]
      end else begin : g_bidir
        assign port_fn = '{en: 1'b1, drive: ~dir_ff[p], dat: latch_ff[p]}; // [R2] [R3] [R8]
      end
      assign fn_tab[p][NF-1] = port_fn;

      if (p == `GPA_PIN_FIRST) begin : g_first
        // analog drivers take the pin with the digital driver off
        assign fn_tab[p][0] = SERIAL_PROG_DATA; // [R15]
        assign fn_tab[p][1] = '{en: VREF_OUT_EN, drive: 1'b0, dat: 1'b0}; // [R15]
        assign fn_tab[p][2] = '{en: CONVERTER_OUT_EN, drive: 1'b0, dat: 1'b0}; // [R15]
        assign fn_tab[p][3] = '{en: cmp_pos_on, drive: 1'b0, dat: 1'b0}; // [R15] [R12]
      end else if (p == `GPA_PIN_THIRD) begin : g_third
        assign fn_tab[p][0] = '{en: DRIVE_FAULT_EN, drive: 1'b0, dat: 1'b0}; // [R16]
        assign fn_tab[p][1] = '{en: TIMER_CLOCK_EN, drive: 1'b0, dat: 1'b0}; // [R16]
        assign fn_tab[p][2] = CMP_ONE_OUTPUT; // [R16] [R14]
        assign fn_tab[p][3] = '{en: EXT_INT_EN, drive: 1'b0, dat: 1'b0}; // [R16]
      end else begin : g_plain
        assign fn_tab[p][0] = off_fn;
        assign fn_tab[p][1] = off_fn;
        assign fn_tab[p][2] = off_fn;
        assign fn_tab[p][3] = off_fn;
      end

      gpa_pin_mux #(
        .NFN (NF)
      ) u_mux (
        .fns (fn_tab[p]),
        .sel (owner[p])
      ); // [R11] [R20] [R14]
    end
  endgenerate

  // driver and pull-up per pin from the winning function
  logic [NP-1:0] drive_now;
  logic [NP-1:0] level_now;
  generate
    for (p = 0; p < NP; p++) begin : g_drv
      assign drive_now[p] = owner[p].drive && (p != `GPA_PIN_IN_ONLY); // [R4]
      assign level_now[p] = owner[p].dat;
    end
  endgenerate
  wire [NP-1:0] pullup_now = wpu_ff & ~drive_now; // [R19]

  // configuration registers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      latch_ff   <= `GPA_RST_LATCH;
      dir_ff     <= `GPA_RST_DIRECTION;
      ansel_ff   <= `GPA_RST_ANALOG_SEL; // [R18]
      wpu_ff     <= `GPA_RST_PULL_UP; // [R17]
      fall_en_ff <= `GPA_RST_FALL_EN;
    end else begin
      latch_ff   <= nxt_latch;
      dir_ff     <= nxt_dir;
      ansel_ff   <= nxt_ansel;
      wpu_ff     <= nxt_wpu;
      fall_en_ff <= nxt_fall_en;
    end
  end

  // change detection and read data
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      flags_ff    <= `GPA_RST_FLAGS;
      din_prev_ff <= 6'h00;
      int_ff      <= 1'b0;
      rdata_ff    <= 8'h00;
    end else begin
      flags_ff    <= nxt_flags;
      din_prev_ff <= din;
      int_ff      <= |nxt_flags;
      rdata_ff    <= nxt_rdata;
    end
  end

  // pin outputs, registered so the pads see no mux glitches
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pin_out_ff  <= 6'h00;
      pin_oen_ff  <= 6'h3f;
      pullup_ff   <= 6'h00;
      din_ff      <= 6'h00;
      cmp_conn_ff <= 1'b0;
    end else begin
      pin_out_ff  <= level_now;
      pin_oen_ff  <= ~drive_now; // [R2] [R3]
      pullup_ff   <= pullup_now;
      din_ff      <= din;
      cmp_conn_ff <= cmp_pos_on; // [R12]
    end
  end

  assign RDATA           = rdata_ff;
  assign PIN_OUT         = pin_out_ff;
  assign PIN_OEN         = pin_oen_ff;
  assign PULLUP_EN       = pullup_ff;
  assign PIN_DIN         = din_ff;
  assign CHANGE_INT      = int_ff;
  assign CMP_POS_CONNECT = cmp_conn_ff;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  AST_IN_ONLY_NO_DRIVE: assert property ( // [R4]
    PIN_OEN[`GPA_PIN_IN_ONLY] == 1'b1)
    else $error("input-only pin is driven");

  AST_DIR_READS_ONE: assert property ( // [R4]
    RD && hit_dir |=> RDATA[`GPA_PIN_IN_ONLY] == 1'b1)
    else $error("input-only direction bit read as zero");

  AST_MCLR_READS_ZERO: assert property ( // [R7]
    RD && hit_levels && MASTER_CLEAR_ENABLE |=> RDATA[`GPA_PIN_IN_ONLY] == 1'b0)
    else $error("input-only pin visible under master clear");

  AST_ANALOG_READS_ZERO: assert property ( // [R9]
    RD && hit_levels && ansel_ff[1] |=> RDATA[1] == 1'b0)
    else $error("analog pin read as one");

  AST_PORT_READ_LEVEL: assert property ( // [R5]
    RD && hit_levels && !ansel_ff[4] |=> RDATA[4] == $past(PIN_IN[4]))
    else $error("port read does not return pin level");

  AST_INPUT_DRIVER_OFF: assert property ( // [R2]
    dir_ff[1] |=> PIN_OEN[1])
    else $error("input pin still driven");

  AST_OUTPUT_DRIVES_LATCH: assert property ( // [R3]
    !dir_ff[5] |=> !PIN_OEN[5] && PIN_OUT[5] == $past(latch_ff[5]))
    else $error("output pin does not drive latch");

  AST_WRITE_TO_LATCH: assert property ( // [R6]
    wr_levels ##1 !wr_port ##1 !dir_ff[0] && !SERIAL_PROG_DATA.en && !VREF_OUT_EN
      && !CONVERTER_OUT_EN && !cmp_pos_on |=> PIN_OUT[0] == $past(WDATA[0], 3))
    else $error("port write did not reach the pin");

  AST_PULLUP_OFF_DRIVEN: assert property ( // [R19]
    !PIN_OEN[2] |-> !PULLUP_EN[2])
    else $error("pull-up on while pin driven");

  AST_ANALOG_NO_EVENT: assert property ( // [R10]
    ansel_ff[4] && fall_en_ff[4] |=> !(flags_ff[4] && !$past(flags_ff[4])))
    else $error("analog pin raised a change flag");

  AST_PROG_DATA_WINS: assert property ( // [R15]
    SERIAL_PROG_DATA.en && SERIAL_PROG_DATA.drive
      |=> !PIN_OEN[0] && PIN_OUT[0] == $past(SERIAL_PROG_DATA.dat))
    else $error("programming data lost the first pin");

  AST_FAULT_WINS: assert property ( // [R16]
    DRIVE_FAULT_EN |=> PIN_OEN[2])
    else $error("fault input did not release the third pin");

  AST_CMP_OUT_ANALOG: assert property ( // [R14]
    ansel_ff[2] && CMP_ONE_OUTPUT.en && CMP_ONE_OUTPUT.drive && !DRIVE_FAULT_EN
      && !TIMER_CLOCK_EN |=> !PIN_OEN[2])
    else $error("comparator output blocked by analog mode");

endmodule

// ==== gpa_port_test.sv ====
// self-checking bench of the six-pin port: registers, pin control, priorities
`timescale 1ns/100ps
`include "gpa_defines.svh"
module gpa_port_test;
  logic               clk = 1'b0;
  logic               rstn = 1'b0;
  logic [8:0]         addr = 9'h000;
  logic [7:0]         wdata = 8'h00;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [7:0]         rdata;
  logic [5:0]         pin_in;
  logic [5:0]         pin_out;
  logic [5:0]         pin_oen;
  logic [5:0]         pullup_en;
  logic [5:0]         pin_din;
  logic               change_int;
  logic               mclr = 1'b0;
  gpa_pkg::gpa_fn_type spd = '0;
  logic               vref = 1'b0;
  logic               conv = 1'b0;
  logic               cmp_en = 1'b0;
  logic [1:0]         cmp_sel = 2'h1;
  logic               flt = 1'b0;
  logic               tck = 1'b0;
  gpa_pkg::gpa_fn_type cmo = '0;
  logic               eint = 1'b0;
  logic               cmp_conn;
  logic [5:0]         ext_en = 6'h3f;
  logic [5:0]         ext_val = 6'h3f;
  int                 mismatches = 0;
  int                 n_compared = 0;
  // [5]/[4]/[3] functions enabled ([2] too on the third pin), [1:0] expected {driver off, off or level}
  logic [5:0]         p0_tab [4] = '{6'b110000, 6'b010011, 6'b001011, 6'b000001};
  logic [5:0]         p2_tab [6] = '{6'b101011, 6'b011011, 6'b001000, 6'b001100,
                                     6'b000111, 6'b000001};

  always #2 clk = ~clk;

  gpa_port uut (
    .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OEN(pin_oen),
    .PULLUP_EN(pullup_en), .PIN_DIN(pin_din), .CHANGE_INT(change_int),
    .MASTER_CLEAR_ENABLE(mclr), .SERIAL_PROG_DATA(spd), .VREF_OUT_EN(vref),
    .CONVERTER_OUT_EN(conv), .CMP_ONE_EN(cmp_en), .CMP_POS_SEL(cmp_sel),
    .DRIVE_FAULT_EN(flt), .TIMER_CLOCK_EN(tck), .CMP_ONE_OUTPUT(cmo),
    .EXT_INT_EN(eint), .CMP_POS_CONNECT(cmp_conn));

  gpa_pin_model board (
    .clk(clk), .pin_out(pin_out), .pin_oen(pin_oen), .pullup_en(pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wreg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, then fall to zero
  task automatic rreg(input logic [8:0] a, input logic [7:0] e, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, rdata, e);
    @(posedge clk);
    #1;
    chk("read data idle", rdata, 8'h00);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // whole run is under two hundred cycles; this cuts a hang
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    settle();
    chk("oen after reset", {2'h0, pin_oen}, 8'h3f);
    chk("pull-up after reset", {2'h0, pullup_en}, 8'h3f);
    rreg(`GPA_OFS_PULL_UP, 8'h3f, "pull-up reg");
    rreg(`GPA_OFS_DIRECTION, 8'h3f, "direction reg");
    rreg(`GPA_OFS_ANALOG_SEL, 8'h37, "analog reg");
    rreg(`GPA_OFS_FALL_ENABLE, 8'h00, "fall enable reg");
    rreg(`GPA_OFS_CHANGE_FLAGS, 8'h00, "flags reg");
    rreg(`GPA_OFS_OUT_LATCH, 8'h00, "latch reg");
    rreg(9'h006, 8'h00, "unmapped read");
    rreg(`GPA_OFS_PIN_LEVELS, 8'h08, "analog pins read");
    chk("din analog", {2'h0, pin_din}, 8'h08);
    @(posedge clk);
    mclr <= 1'b1;
    settle();
    rreg(`GPA_OFS_PIN_LEVELS, 8'h00, "master clear read");
    @(posedge clk);
    mclr <= 1'b0;
    $display("test reset done");

    wreg(`GPA_OFS_ANALOG_SEL, 8'h00);
    ext_val <= 6'h2a;
    settle();
    rreg(`GPA_OFS_PIN_LEVELS, 8'h2a, "pin levels");
    chk("din digital", {2'h0, pin_din}, 8'h2a);
    wreg(`GPA_OFS_OUT_LATCH, 8'hff);
    rreg(`GPA_OFS_OUT_LATCH, 8'h37, "latch masked");
    ext_en <= 6'h08;
    wreg(`GPA_OFS_DIRECTION, 8'h00);
    rreg(`GPA_OFS_DIRECTION, 8'h08, "input only dir");
    settle();
    chk("oen outputs", {2'h0, pin_oen}, 8'h08);
    chk("driven levels", {2'h0, pin_out & ~pin_oen}, 8'h37);
    chk("pull-up off when driven", {2'h0, pullup_en}, 8'h08);
    wreg(`GPA_OFS_PIN_LEVELS, 8'h15);
    rreg(`GPA_OFS_OUT_LATCH, 8'h15, "port write to latch");
    settle();
    chk("driven after port write", {2'h0, pin_out & ~pin_oen}, 8'h15);
    rreg(`GPA_OFS_PIN_LEVELS, 8'h1d, "driven pins read");
    wreg(`GPA_OFS_ANALOG_SEL, 8'h37);
    settle();
    chk("analog pin still drives", {2'h0, pin_out & ~pin_oen}, 8'h15);
    rreg(`GPA_OFS_PIN_LEVELS, 8'h08, "analog driven read");
    wreg(`GPA_OFS_ANALOG_SEL, 8'h00);
    $display("test direction done");

    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      spd <= '{p0_tab[i][5], 1'b1, 1'b0};
      vref <= p0_tab[i][4];
      conv <= p0_tab[i][3];
      settle();
      chk("first pin owner", {6'h0, pin_oen[0], pin_oen[0] | pin_out[0]},
          {6'h0, p0_tab[i][1:0]});
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      flt <= p2_tab[i][5];
      tck <= p2_tab[i][4];
      cmo <= '{p2_tab[i][3], 1'b1, 1'b0};
      eint <= p2_tab[i][2];
      settle();
      chk("third pin owner", {6'h0, pin_oen[2], pin_oen[2] | pin_out[2]},
          {6'h0, p2_tab[i][1:0]});
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      cmp_en <= (i != 2);
      cmp_sel <= (i == 1) ? 2'h1 : `GPA_CMP_SEL_FIRST;
      settle();
      chk("comparator connect", {7'h0, cmp_conn}, {7'h0, i == 0});
      chk("first pin comparator", {6'h0, pin_oen[0], pin_oen[0] | pin_out[0]},
          (i == 0) ? 8'h03 : 8'h01);
    end
    $display("test priority done");

    ext_en <= 6'h3f;
    ext_val <= 6'h3f;
    wreg(`GPA_OFS_DIRECTION, 8'h3f);
    wreg(`GPA_OFS_FALL_ENABLE, 8'h3f);
    settle();
    wreg(`GPA_OFS_CHANGE_FLAGS, 8'h00);
    ext_val <= 6'h2f;
    settle();
    chk("change event", {7'h0, change_int}, 8'h01);
    rreg(`GPA_OFS_CHANGE_FLAGS, 8'h10, "falling flag");
    wreg(`GPA_OFS_CHANGE_FLAGS, 8'h00);
    ext_val <= 6'h3f;
    settle();
    chk("event cleared", {7'h0, change_int}, 8'h00);
    wreg(`GPA_OFS_ANALOG_SEL, 8'h10);
    ext_val <= 6'h2f;
    settle();
    chk("analog pin no event", {7'h0, change_int}, 8'h00);
    rreg(`GPA_OFS_CHANGE_FLAGS, 8'h00, "analog pin no flag");
    $display("test change done");
    give_verdict();
  end
endmodule
